// File: sioc_cs_decode.sv
// decodes a channel status word into link flags
// assumes the word was read after a start or transfer cycle
`include "sioc_defines.svh"
module sioc_cs_decode import sioc_pkg::*; (
  input  wire logic [31:0] i_cs,
  input  wire logic [7:0]  i_rev,
  input  wire logic        i_transfer_cycle_command_seen,
  input  wire logic        i_nstart,
  output sioc_link_t       o_link
);
  logic rev_new;
  always_comb begin
    rev_new = (i_rev >= `SIOC_REV_REMOTE);
    o_link.healthy        = (i_cs[15:8] == 8'h00);
    o_link.not_up         = i_cs[15];
    o_link.far_id_missing = i_cs[14];
    o_link.comm_err       = i_cs[13];
    o_link.remote_fault   = i_cs[8];
    // top byte undefined on old firmware, and until a transfer cycle or normal start
    o_link.remote_valid   = rev_new && (i_transfer_cycle_command_seen || i_nstart);
    o_link.remote_faults  = o_link.remote_valid ? i_cs[31:24] : 8'h00;
  end
endmodule

// File: sioc_defines.svh
// named constants for the serial i/o channel discovery controller
// assumes inclusion by the controller modules, the monitor and the bench
`ifndef SIOC_DEFINES_SVH
`define SIOC_DEFINES_SVH
// device command words
`define SIOC_CMD_STOPALL  32'h0000_0800
`define SIOC_CMD_NSTART   32'h0000_0900
`define SIOC_CMD_SSTART   32'h0000_0F00
`define SIOC_CMD_TRANSFER_CYCLE_COMMAND     32'h0000_1000
`define SIOC_CH_ONE       8'h01
// remote read opcodes placed in the status word top byte
`define SIOC_RRD_WORD     8'h45
`define SIOC_RRD_LONG     8'h46
// device register map, per channel block at base
`define SIOC_DEV_CMD      8'h00
`define SIOC_DEV_DATA     8'h01
`define SIOC_DEV_CH_BASE  8'h10
`define SIOC_IDX_CS       2'h0
`define SIOC_IDX_IF0      2'h1
`define SIOC_IDX_IF2      2'h3
// descriptor values
`define SIOC_REC_ELEM     8'hA0
`define SIOC_REC_MODE     8'hB0
`define SIOC_MAX_BITS     8'h60
`define SIOC_TYPE_MAX     8'h07
`define SIOC_TYPE_UNS     8'h02
`define SIOC_TYPE_SGN     8'h03
`define SIOC_TYPE_NVUNS   8'h04
`define SIOC_TYPE_NVSGN   8'h05
`define SIOC_DIR_IN       8'h00
`define SIOC_DIR_BI       8'h40
`define SIOC_DIR_OUT      8'h80
`define SIOC_MODE_HW      8'h00
`define SIOC_MODE_SW      8'h01
`define SIOC_REV_REMOTE   8'h1D
`define SIOC_ENTRY_STEP   16'h0002
`define SIOC_ENTRY_MAX    8'hFF
`define SIOC_WAIT_CYC     3'h4
// own register map
`define SIOC_REG_CTRL     4'h0
`define SIOC_REG_CFG      4'h1
`define SIOC_REG_STAT     4'h2
`define SIOC_REG_CS       4'h3
`define SIOC_REG_STICKY   4'h4
`define SIOC_REG_PTR      4'h5
`define SIOC_REG_DISC     4'h6
`define SIOC_REG_BITS     4'h7
`define SIOC_REG_LAST     4'h8
`endif

// File: sioc_dev_model.sv
// behavioural link engine with one channel and a remote memory
// assumes strobes from the controller last one clock
module sioc_dev_model #(parameter logic [7:0] CH_BASE = 8'h14) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [7:0]  i_lflt,
  input  wire logic [7:0]  i_rflt,
  input  wire logic [7:0]  i_fail,
  input  wire logic [15:0] i_ptr,
  input  wire logic        i_slow,
  output logic      [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cmd, data, cs, if0, if2, rd;
  logic [7:0]  mem [0:1023];
  logic [7:0]  sticky;
  logic        setup;
  int          cnt;
  task automatic put(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) mem[a+i] = v[8*i+:8];
  endtask
  initial begin
    logic [31:0] recs [7] = '{32'h0002_10A0, 32'h8003_08A0, 32'h4001_04A0,
      32'h0001_00B0, 32'h0000_01B0, 32'h0000_0077, 32'h0002_61A0};
    for (int i = 0; i < 1024; i++) mem[i] = 8'hA5;
    for (int k = 0; k < 8; k++) put(256 + 2*k, (k < 7) ? 512 + 16*k : 0);
    for (int k = 0; k < 7; k++) put(512 + 16*k, recs[k]);
  end
  always_comb begin
    case (i_addr)
      8'h00: rd = cmd;
      8'h01: rd = data;
      CH_BASE: rd = cs;
      CH_BASE + 8'h01: rd = if0;
      CH_BASE + 8'h03: rd = if2;
      default: rd = 32'hDEAD_BEEF;
    endcase
  end
  always @(posedge i_clk) begin
    if (i_re) o_rdata <= rd;
    if (i_rst) begin
      {cmd, data, cs, if0, if2, o_rdata} <= '0;
      sticky <= 8'h00;
      setup <= 1'b0;
      cnt <= 0;
    end else if (i_we && i_addr == 8'h00) begin
      cmd <= i_wdata;
      cnt <= i_slow ? 40 : 2;
      // remote reads pass through only after a setup start; other transfer cycles load the fault byte into the status word
      setup <= (i_wdata[15:8] == 8'h0F) || (setup && i_wdata[15:8] == 8'h10);
    end else if (i_we && i_addr == CH_BASE) begin
      cs <= i_wdata;
    end else if (cmd != 0 && cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cmd != 0) begin
      cmd <= 32'h0000_0000;
      data <= {24'h00_0000, i_fail};
      if (cmd[15:8] == 8'h08) sticky <= 8'h00;
      else if (cmd[15:8] == 8'h10 && setup && cs[31:24] == 8'h46)
        if0 <= {mem[cs[9:0]+3], mem[cs[9:0]+2], mem[cs[9:0]+1], mem[cs[9:0]]};
      else if (cmd[15:8] == 8'h10 && setup && cs[31:24] == 8'h45)
        if0 <= {16'hA5A5, mem[cs[9:0]+1], mem[cs[9:0]]};
      else begin
        sticky <= sticky | i_lflt;
        cs <= {i_rflt, 8'h3C, 8'h00, sticky | i_lflt};
        if (cmd[15:8] != 8'h10) if2 <= {16'h0000, i_ptr};
      end
    end
  end
endmodule

// File: sioc_host.sv
// host-side controller: issues channel commands, collects status, walks index table
// assumes device registers answer one cycle after a read strobe and hold until the next read
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "sioc_defines.svh"
module sioc_host import sioc_pkg::*; (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [31:0] o_rdata,
  output logic             o_busy,
  input  wire logic [31:0] i_dev_rdata,
  output logic      [7:0]  o_dev_addr,
  output logic      [31:0] o_dev_wdata,
  output logic             o_dev_we,
  output logic             o_dev_re
);
  function automatic logic [7:0] dev_addr(input logic [2:0] ch, input logic [1:0] idx);
    dev_addr = `SIOC_DEV_CH_BASE | {3'h0, ch, idx};
  endfunction

  function automatic logic [31:0] cmd_word(input sioc_op_t op, input logic [2:0] ch);
    logic [31:0] mask;
    mask = {24'h00_0000, `SIOC_CH_ONE << ch};
    unique case (op)
      OP_STOP:   cmd_word = `SIOC_CMD_STOPALL;
      OP_NSTART: cmd_word = `SIOC_CMD_NSTART | mask;
      OP_SSTART: cmd_word = `SIOC_CMD_SSTART | mask;
      default:   cmd_word = `SIOC_CMD_TRANSFER_CYCLE_COMMAND | mask;
    endcase
  endfunction

  // device read data crosses in from outside: two stages before use
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_q <= 32'h0000_0000;
      sync2_q <= 32'h0000_0000;
    end else begin
      sync1_q <= i_dev_rdata;
      sync2_q <= sync1_q;
    end
  end

  sioc_state_t state_q, state_d, after_q, after_d;
  sioc_op_t    op_q, op_d;
  logic [2:0]  wait_q, wait_d, ch_q, ch_d;
  logic        sub_q, sub_d, setup_q, setup_d, started_q, started_d, nstart_q, nstart_d;
  logic        transfer_cycle_command_q, transfer_cycle_command_d, err_q, err_d, done_q, done_d, nodisc_q, nodisc_d;
  logic [31:0] rd_q, rd_d, cs_q, cs_d, last_q, last_d;
  logic [7:0]  fail_q, fail_d, sticky_q, sticky_d, rev_q, rev_d, ent_q, ent_d;
  logic [15:0] ptr_q, ptr_d, walk_q, walk_d, rec_q, rec_d, in_bits_q, in_bits_d;
  logic [15:0] out_bits_q, out_bits_d;
  logic [7:0]  n_elem_q, n_elem_d, n_mode_q, n_mode_d, n_unk_q, n_unk_d, n_bad_q, n_bad_d;
  logic [7:0]  num_q, num_d;
  logic [31:0] rdata_d, dwdata_d;
  logic [7:0]  daddr_d;
  logic        busy_d, dwe_d, dre_d;
  sioc_link_t  link;
  sioc_rec_t   rec;
  sioc_op_t    req_op;

  sioc_cs_decode u_cs (
    .i_cs        (cs_q),
    .i_rev       (rev_q),
    .i_transfer_cycle_command_seen (transfer_cycle_command_q),
    .i_nstart    (nstart_q),
    .o_link      (link)
  );

  sioc_rec_class u_rec (
    .i_long (rd_q),
    .o_rec  (rec)
  );

  always_comb begin
    state_d = state_q;   after_d = after_q;     op_d = op_q;        wait_d = wait_q;
    ch_d = ch_q;         sub_d = sub_q;         setup_d = setup_q;  started_d = started_q;
    nstart_d = nstart_q; transfer_cycle_command_d = transfer_cycle_command_q;       err_d = err_q;      done_d = done_q;
    nodisc_d = nodisc_q; rd_d = rd_q;           cs_d = cs_q;        last_d = last_q;
    fail_d = fail_q;     sticky_d = sticky_q;   rev_d = rev_q;      ent_d = ent_q;
    ptr_d = ptr_q;       walk_d = walk_q;       rec_d = rec_q;      in_bits_d = in_bits_q;
    out_bits_d = out_bits_q; n_elem_d = n_elem_q; n_mode_d = n_mode_q;
    n_unk_d = n_unk_q;   n_bad_d = n_bad_q;     num_d = num_q;
    dwe_d = 1'b0;        dre_d = 1'b0;          daddr_d = o_dev_addr;
    dwdata_d = o_dev_wdata;
    req_op = sioc_op_t'(i_wdata[2:0]);
    // software register writes; orders while busy are dropped
    if (i_we && (i_addr == `SIOC_REG_CFG)) begin
      rev_d = i_wdata[7:0];
    end
    unique case (state_q)
      ST_IDLE: begin
        if (i_we && (i_addr == `SIOC_REG_CTRL) && (i_wdata[2:0] <= OP_WALK)) begin
          op_d = req_op;
          ch_d = i_wdata[6:4];
          done_d = 1'b0;
          err_d = 1'b0;
          if (req_op == OP_WALK) begin
            if (!setup_q || !started_q) begin
              err_d = 1'b1;
              state_d = ST_DONE;
            end else if (ptr_q == 16'h0000) begin
              nodisc_d = 1'b1;
              state_d = ST_DONE;
            end else begin
              walk_d = ptr_q;
              sub_d = 1'b0;
              ent_d = 8'h00;
              n_elem_d = 8'h00;
              n_mode_d = 8'h00;
              n_unk_d = 8'h00;
              n_bad_d = 8'h00;
              num_d = 8'h00;
              in_bits_d = 16'h0000;
              out_bits_d = 16'h0000;
              state_d = ST_WALK_CS;
            end
          end else if ((req_op == OP_TRANSFER_CYCLE_COMMAND) && !started_q) begin
            // a transfer cycle is refused unless the latest start, on any channel, succeeded and no stop followed
            err_d = 1'b1;
            state_d = ST_DONE;
          end else begin
            state_d = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        dwe_d = 1'b1;
        daddr_d = `SIOC_DEV_CMD;
        dwdata_d = cmd_word(op_q, ch_q);
        state_d = ST_POLL_RD;
      end
      ST_POLL_RD: begin
        dre_d = 1'b1;
        daddr_d = `SIOC_DEV_CMD;
        wait_d = `SIOC_WAIT_CYC;
        after_d = ST_POLL_EV;
        state_d = ST_WAIT;
      end
      ST_POLL_EV: begin
        // no timeout: a hung command polls until reset, since a stop is dropped while busy
        state_d = (rd_q == 32'h0000_0000) ? ST_DATA_RD : ST_POLL_RD;
      end
      ST_DATA_RD: begin
        dre_d = 1'b1;
        daddr_d = `SIOC_DEV_DATA;
        wait_d = `SIOC_WAIT_CYC;
        after_d = ST_DATA_EV;
        state_d = ST_WAIT;
      end
      ST_DATA_EV: begin
        fail_d = rd_q[7:0];
        if (op_q == OP_STOP) begin
          sticky_d = 8'h00;
          setup_d = 1'b0;
          started_d = 1'b0;
          nstart_d = 1'b0;
          transfer_cycle_command_d = 1'b0;
          nodisc_d = 1'b0;
          ptr_d = 16'h0000;
          cs_d = 32'h0000_0000;
          state_d = ST_DONE;
        end else if (op_q == OP_WALK) begin
          if (rd_q[ch_q]) begin
            err_d = 1'b1;
            state_d = ST_DONE;
          end else begin
            state_d = ST_IF0_RD;
          end
        end else begin
          if (op_q == OP_TRANSFER_CYCLE_COMMAND) begin
            transfer_cycle_command_d = !rd_q[ch_q];
          end else begin
            started_d = !rd_q[ch_q];
            setup_d = (op_q == OP_SSTART);
            nstart_d = (op_q == OP_NSTART);
          end
          err_d = rd_q[ch_q];
          state_d = ST_CS_RD;
        end
      end
      ST_CS_RD: begin
        dre_d = 1'b1;
        daddr_d = dev_addr(ch_q, `SIOC_IDX_CS);
        wait_d = `SIOC_WAIT_CYC;
        after_d = ST_CS_EV;
        state_d = ST_WAIT;
      end
      ST_CS_EV: begin
        cs_d = rd_q;
        sticky_d = sticky_q | rd_q[7:0];
        state_d = (op_q == OP_TRANSFER_CYCLE_COMMAND) ? ST_DONE : ST_IF2_RD;
      end
      ST_IF2_RD: begin
        dre_d = 1'b1;
        daddr_d = dev_addr(ch_q, `SIOC_IDX_IF2);
        wait_d = `SIOC_WAIT_CYC;
        after_d = ST_IF2_EV;
        state_d = ST_WAIT;
      end
      ST_IF2_EV: begin
        ptr_d = rd_q[15:0];
        nodisc_d = (rd_q[15:0] == 16'h0000);
        state_d = ST_DONE;
      end
      ST_WALK_CS: begin
        // status word carries the remote read only in setup mode
        dwe_d = 1'b1;
        daddr_d = dev_addr(ch_q, `SIOC_IDX_CS);
        dwdata_d = sub_q ? {`SIOC_RRD_LONG, 8'h00, rec_q}
                         : {`SIOC_RRD_WORD, 8'h00, walk_q};
        state_d = ST_CMD;
      end
      ST_IF0_RD: begin
        dre_d = 1'b1;
        daddr_d = dev_addr(ch_q, `SIOC_IDX_IF0);
        wait_d = `SIOC_WAIT_CYC;
        after_d = ST_IF0_EV;
        state_d = ST_WAIT;
      end
      ST_IF0_EV: begin
        if (!sub_q) begin
          if (rd_q[15:0] == 16'h0000) begin
            state_d = ST_DONE;
          end else if (ent_q == `SIOC_ENTRY_MAX) begin
            err_d = 1'b1;
            state_d = ST_DONE;
          end else begin
            rec_d = rd_q[15:0];
            sub_d = 1'b1;
            state_d = ST_WALK_CS;
          end
        end else begin
          last_d = rd_q;
          if (rec.is_elem) begin
            n_elem_d = n_elem_q + 8'h01;
            if (!rec.elem_ok) begin
              n_bad_d = n_bad_q + 8'h01;
            end else begin
              // running bit totals give each element's packing offset
              if (rec.dir_in) begin
                in_bits_d = in_bits_q + {8'h00, rec.size};
              end
              if (rec.dir_out) begin
                out_bits_d = out_bits_q + {8'h00, rec.size};
              end
              // scale bounds and strings stay in the remote; software fetches them
              if (rec.numeric) begin
                num_d = num_q + 8'h01;
              end
            end
          end else if (rec.is_mode) begin
            n_mode_d = n_mode_q + 8'h01;
          end else begin
            n_unk_d = n_unk_q + 8'h01;
          end
          ent_d = ent_q + 8'h01;
          walk_d = walk_q + `SIOC_ENTRY_STEP;
          sub_d = 1'b0;
          state_d = ST_WALK_CS;
        end
      end
      ST_WAIT: begin
        if (wait_q == 3'h0) begin
          rd_d = sync2_q;
          state_d = after_q;
        end else begin
          wait_d = wait_q - 3'h1;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
    rdata_d = 32'h0000_0000;
    if (i_re) begin
      unique case (i_addr)
        `SIOC_REG_CTRL:   rdata_d = {25'h000_0000, ch_q, 1'b0, op_q};
        `SIOC_REG_CFG:    rdata_d = {24'h00_0000, rev_q};
        `SIOC_REG_STAT:   rdata_d = {fail_q, 10'h000, link.remote_valid, link.remote_fault,
                                     link.comm_err, link.far_id_missing, link.not_up,
                                     link.healthy, transfer_cycle_command_q, nstart_q, nodisc_q, setup_q,
                                     started_q, err_q, done_q, o_busy};
        `SIOC_REG_CS:     rdata_d = {link.remote_faults, cs_q[23:0]};
        `SIOC_REG_STICKY: rdata_d = {24'h00_0000, sticky_q};
        `SIOC_REG_PTR:    rdata_d = {walk_q, ptr_q};
        `SIOC_REG_DISC:   rdata_d = {n_unk_q, n_mode_q, n_elem_q, n_bad_q};
        `SIOC_REG_BITS:   rdata_d = {out_bits_q, in_bits_q};
        `SIOC_REG_LAST:   rdata_d = last_q;
        default:          rdata_d = {24'h00_0000, num_q & {8{i_addr == 4'h9}}};
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;   after_q <= ST_IDLE;    op_q <= OP_STOP;    wait_q <= 3'h0;
      ch_q <= 3'h0;         sub_q <= 1'b0;         setup_q <= 1'b0;    started_q <= 1'b0;
      nstart_q <= 1'b0;     transfer_cycle_command_q <= 1'b0;        err_q <= 1'b0;      done_q <= 1'b0;
      nodisc_q <= 1'b0;     rd_q <= 32'h0000_0000; cs_q <= 32'h0000_0000;
      last_q <= 32'h0000_0000; fail_q <= 8'h00;    sticky_q <= 8'h00;  rev_q <= 8'h00;
      ent_q <= 8'h00;       ptr_q <= 16'h0000;     walk_q <= 16'h0000; rec_q <= 16'h0000;
      in_bits_q <= 16'h0000; out_bits_q <= 16'h0000; n_elem_q <= 8'h00; n_mode_q <= 8'h00;
      n_unk_q <= 8'h00;     n_bad_q <= 8'h00;      num_q <= 8'h00;
      o_rdata <= 32'h0000_0000; o_busy <= 1'b0;    o_dev_addr <= 8'h00;
      o_dev_wdata <= 32'h0000_0000; o_dev_we <= 1'b0; o_dev_re <= 1'b0;
    end else begin
      state_q <= state_d;   after_q <= after_d;    op_q <= op_d;       wait_q <= wait_d;
      ch_q <= ch_d;         sub_q <= sub_d;        setup_q <= setup_d; started_q <= started_d;
      nstart_q <= nstart_d; transfer_cycle_command_q <= transfer_cycle_command_d;      err_q <= err_d;     done_q <= done_d;
      nodisc_q <= nodisc_d; rd_q <= rd_d;          cs_q <= cs_d;
      last_q <= last_d;     fail_q <= fail_d;      sticky_q <= sticky_d; rev_q <= rev_d;
      ent_q <= ent_d;       ptr_q <= ptr_d;        walk_q <= walk_d;   rec_q <= rec_d;
      in_bits_q <= in_bits_d; out_bits_q <= out_bits_d; n_elem_q <= n_elem_d;
      n_mode_q <= n_mode_d; n_unk_q <= n_unk_d;    n_bad_q <= n_bad_d; num_q <= num_d;
      o_rdata <= rdata_d;   o_busy <= busy_d;      o_dev_addr <= daddr_d;
      o_dev_wdata <= dwdata_d; o_dev_we <= dwe_d;  o_dev_re <= dre_d;
    end
  end
endmodule

// File: sioc_host_monitor.sv
// port assertions for the channel discovery host controller
// assumes one clock domain and a synchronous active high reset
`include "sioc_defines.svh"
module sioc_host_monitor import sioc_pkg::*; (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_we,
  input wire logic        i_re,
  input wire logic [31:0] o_rdata,
  input wire logic        o_busy,
  input wire logic [31:0] i_dev_rdata,
  input wire logic [7:0]  o_dev_addr,
  input wire logic [31:0] o_dev_wdata,
  input wire logic        o_dev_we,
  input wire logic        o_dev_re
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic ctrl_ok;
  assign ctrl_ok = i_we && i_addr == `SIOC_REG_CTRL && !o_busy;
  sequence cs_req_s;
    o_dev_we && o_dev_addr[4] && o_dev_addr[1:0] == `SIOC_IDX_CS;
  endsequence
  sequence transfer_cycle_command_s;
    o_dev_we && o_dev_addr == `SIOC_DEV_CMD && o_dev_wdata[31:8] == 24'h00_0010;
  endsequence
  // command word leaves two edges after the accepting edge
  rdata_idle_a: assert property (!$past(i_re) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  busy_accept_a: assert property (ctrl_ok && i_wdata[2:0] <= 3'h4 |=> o_busy)
    else $error("accepted command did not raise busy");
  stop_word_a: assert property (ctrl_ok && i_wdata[2:0] == 3'h0 |-> ##2 o_dev_we
    && o_dev_addr == `SIOC_DEV_CMD && o_dev_wdata == `SIOC_CMD_STOPALL)
    else $error("stop did not write the stop command");
  start_word_a: assert property (ctrl_ok && i_wdata[2:0] == 3'h1 |-> ##2 o_dev_we
    && o_dev_wdata == (`SIOC_CMD_NSTART | (32'h0000_0001 << $past(i_wdata[6:4], 2))))
    else $error("normal start word wrong");
  poll_cmd_a: assert property (o_dev_we && o_dev_addr == `SIOC_DEV_CMD
    |-> ##[1:4] o_dev_re && o_dev_addr == `SIOC_DEV_CMD)
    else $error("command not followed by a command poll");
  read_gap_a: assert property (o_dev_re |=> !(o_dev_re || o_dev_we) [*4])
    else $error("device strobe too soon after a read");
  walk_transfer_cycle_command_a: assert property (cs_req_s |-> ##[1:12] transfer_cycle_command_s)
    else $error("remote read request not followed by a transfer cycle");
  walk_word_a: assert property (cs_req_s |-> o_dev_wdata[23:16] == 8'h00
    && o_dev_wdata[31:24] inside {`SIOC_RRD_WORD, `SIOC_RRD_LONG})
    else $error("remote read request malformed");
endmodule
bind sioc_host sioc_host_monitor mon_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
  .o_busy(o_busy), .i_dev_rdata(i_dev_rdata), .o_dev_addr(o_dev_addr),
  .o_dev_wdata(o_dev_wdata), .o_dev_we(o_dev_we), .o_dev_re(o_dev_re));

// File: sioc_host_tb.sv
// self-checking bench for the channel discovery host controller
// assumes the device model serves channel one only
`include "sioc_defines.svh"
module sioc_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, i_we = 1'b0, i_re = 1'b0, re_d = 1'b0;
  logic        slow = 1'b0, o_busy, dev_we, dev_re;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  lflt = 8'h00, rflt = 8'h00, fail = 8'h00, l1, dev_addr;
  logic [15:0] ptr = 16'h0100;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, dev_rdata, dev_wdata;
  logic [63:0] exp_q [$];
  logic [63:0] ent;
  int          failures = 0, num_checks = 0, cycles = 0;
  always #50 i_core_clk = ~i_core_clk;
  sioc_host dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_busy(o_busy),
    .i_dev_rdata(dev_rdata), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata),
    .o_dev_we(dev_we), .o_dev_re(dev_re));
  sioc_dev_model dev_u (.i_clk(i_core_clk), .i_rst(i_rst), .i_addr(dev_addr),
    .i_wdata(dev_wdata), .i_we(dev_we), .i_re(dev_re), .i_lflt(lflt), .i_rflt(rflt),
    .i_fail(fail), .i_ptr(ptr), .i_slow(slow), .o_rdata(dev_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // answer stands only in the cycle after the strobe, so compare there
  always @(posedge i_core_clk) begin
    cycles++;
    if (re_d) begin
      ent = exp_q.pop_front();
      check(o_rdata & ent[63:32], ent[31:0]);
    end
    re_d <= i_re;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_core_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_core_clk);
    exp_q.push_back({m, e});
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_core_clk);
    i_re <= 1'b0;
  endtask
  // channel one in every command; far side randomly prompt or slow
  task automatic op(input logic [2:0] o);
    slow <= 1'($urandom % 2);
    wr(`SIOC_REG_CTRL, {25'h000_0000, 3'h1, 1'b0, o});
    #1;
    while (o_busy) @(posedge i_core_clk);
  endtask
  initial begin
    void'($urandom(14932));
    l1 = 8'($urandom);
    rflt <= 8'($urandom);
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // all-zero status byte decodes as healthy even before any start
    rd(`SIOC_REG_STAT, 32'hFFFF_FFFF, 32'h0000_0100);
    rd(4'hA, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`SIOC_REG_CFG, 32'h0000_001C);
    rd(`SIOC_REG_CFG, 32'h0000_00FF, 32'h0000_001C);
    wr(`SIOC_REG_CTRL, 32'h0000_0015);
    rd(`SIOC_REG_STAT, 32'h0000_0007, 32'h0000_0000);
    op(3'h3);
    rd(`SIOC_REG_STAT, 32'h0000_000E, 32'h0000_0006);
    $display("test registers and early transfer done");
    lflt <= l1;
    op(3'h1);
    rd(`SIOC_REG_STAT, 32'h0000_010E, 32'h0000_010A);
    rd(`SIOC_REG_CS, 32'hFFFF_FFFF, {16'h003C, 8'h00, l1});
    rd(`SIOC_REG_PTR, 32'h0000_FFFF, 32'h0000_0100);
    rd(`SIOC_REG_STICKY, 32'h0000_00FF, {24'h00_0000, l1});
    wr(`SIOC_REG_CFG, 32'h0000_001D);
    lflt <= 8'($urandom);
    op(3'h3);
    rd(`SIOC_REG_CS, 32'hFFFF_FFFF, {rflt, 16'h3C00, l1 | lflt});
    wr(`SIOC_REG_CS, 32'hFFFF_FFFF);
    rd(`SIOC_REG_CS, 32'hFFFF_FFFF, {rflt, 16'h3C00, l1 | lflt});
    rd(`SIOC_REG_STICKY, 32'h0000_00FF, {24'h00_0000, l1 | lflt});
    rd(`SIOC_REG_STAT, 32'h0000_0084, 32'h0000_0080);
    fail <= 8'h02;
    op(3'h3);
    rd(`SIOC_REG_STAT, 32'hFF00_0004, 32'h0200_0004);
    fail <= 8'h00;
    op(3'h0);
    rd(`SIOC_REG_STICKY, 32'h0000_00FF, 32'h0000_0000);
    rd(`SIOC_REG_STAT, 32'h0000_0018, 32'h0000_0000);
    $display("test status word and faults done");
    ptr <= 16'h0000;
    op(3'h2);
    op(3'h4);
    rd(`SIOC_REG_STAT, 32'h0000_0030, 32'h0000_0030);
    op(3'h0);
    ptr <= 16'h0100;
    op(3'h2);
    op(3'h4);
    // seven records: four element (one oversized), two mode, one unknown
    rd(`SIOC_REG_DISC, 32'hFFFF_FFFF, 32'h0102_0401);
    rd(`SIOC_REG_BITS, 32'hFFFF_FFFF, 32'h000C_0014);
    rd(`SIOC_REG_LAST, 32'hFFFF_FFFF, 32'h0002_61A0);
    rd(4'h9, 32'hFFFF_FFFF, 32'h0000_0002);
    rd(`SIOC_REG_PTR, 32'hFFFF_FFFF, 32'h010E_0100);
    rd(`SIOC_REG_STAT, 32'h0000_0026, 32'h0000_0002);
    $display("test discovery walk done");
    repeat (3) @(posedge i_core_clk);
    give_verdict();
  end
endmodule

// File: sioc_pkg.sv
// types shared by the channel discovery controller
// assumes sioc_defines.svh is on the include path
package sioc_pkg;
  typedef enum logic [2:0] {
    OP_STOP   = 3'h0,
    OP_NSTART = 3'h1,
    OP_SSTART = 3'h2,
    OP_TRANSFER_CYCLE_COMMAND   = 3'h3,
    OP_WALK   = 3'h4
  } sioc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CMD     = 4'b0001,
    ST_POLL_RD = 4'b0011,
    ST_POLL_EV = 4'b0010,
    ST_DATA_RD = 4'b0110,
    ST_DATA_EV = 4'b0111,
    ST_CS_RD   = 4'b0101,
    ST_CS_EV   = 4'b0100,
    ST_IF2_RD  = 4'b1100,
    ST_IF2_EV  = 4'b1101,
    ST_WALK_CS = 4'b1111,
    ST_IF0_RD  = 4'b1110,
    ST_IF0_EV  = 4'b1010,
    ST_WAIT    = 4'b1001,
    ST_DONE    = 4'b1000
  } sioc_state_t;

  typedef struct packed {
    logic       healthy;
    logic       not_up;
    logic       far_id_missing;
    logic       comm_err;
    logic       remote_fault;
    logic       remote_valid;
    logic [7:0] remote_faults;
  } sioc_link_t;

  typedef struct packed {
    logic       is_elem;
    logic       is_mode;
    logic       elem_ok;
    logic       numeric;
    logic       signed_n;
    logic       dir_in;
    logic       dir_out;
    logic       mode_sw;
    logic [7:0] size;
  } sioc_rec_t;
endpackage

// File: sioc_rec_class.sv
// classifies the first four bytes of a descriptor record
// assumes bytes arrive least significant first from a long remote read
`include "sioc_defines.svh"
module sioc_rec_class import sioc_pkg::*; (
  input  wire logic [31:0] i_long,
  output sioc_rec_t        o_rec
);
  logic [7:0] kind;
  logic [7:0] dtype;
  logic [7:0] dir;
  always_comb begin
    kind  = i_long[7:0];
    dtype = i_long[23:16];
    dir   = i_long[31:24];
    o_rec.is_elem  = (kind == `SIOC_REC_ELEM);
    o_rec.is_mode  = (kind == `SIOC_REC_MODE);
    o_rec.size     = i_long[15:8];
    o_rec.dir_in   = (dir == `SIOC_DIR_IN) || (dir == `SIOC_DIR_BI);
    o_rec.dir_out  = (dir == `SIOC_DIR_OUT) || (dir == `SIOC_DIR_BI);
    // size 1..96 fits the three interface words
    o_rec.elem_ok  = (o_rec.size != 8'h00) && (o_rec.size <= `SIOC_MAX_BITS)
                     && (dtype <= `SIOC_TYPE_MAX)
                     && (o_rec.dir_in || o_rec.dir_out);
    o_rec.numeric  = (dtype >= `SIOC_TYPE_UNS) && (dtype <= `SIOC_TYPE_NVSGN);
    o_rec.signed_n = (dtype == `SIOC_TYPE_SGN) || (dtype == `SIOC_TYPE_NVSGN);
    // mode record: index in byte 1, kind in byte 2
    o_rec.mode_sw  = (dtype == `SIOC_MODE_SW);
  end
endmodule
